// [dv/array_engine_model.sv]
// behavioural array engine that answers program and erase starts
`timescale 1ns/10ps
`default_nettype none
module array_engine_model #(
	parameter int DoneDelay = 20
) (
	input  wire logic clk,
	input  wire logic rst_b,
	input  wire logic arrayProgram,
	input  wire logic arrayErase,
	input  wire logic arrayChip,
	input  wire logic suspendReq,
	input  wire logic resumeReq,
	input  wire logic abortReq,
	output logic      arrayDone
);
	logic [7:0] countReg;
	logic       runReg;
	logic       heldReg;
	// the count is kept while held so a resume finishes the remaining work only
	always_ff @(posedge clk) begin
		arrayDone <= 1'b0;
		if (!rst_b || abortReq) begin
			runReg <= 1'b0;
			heldReg <= 1'b0;
			countReg <= 8'h00;
		end else if (arrayProgram || arrayErase || arrayChip) begin
			runReg <= 1'b1;
			countReg <= 8'(DoneDelay);
		end else if (suspendReq && runReg) begin
			runReg <= 1'b0;
			heldReg <= 1'b1;
		end else if (resumeReq && heldReg) begin
			runReg <= 1'b1;
			heldReg <= 1'b0;
		end else if (runReg) begin
			if (countReg == 8'h00) begin
				arrayDone <= 1'b1;
				runReg <= 1'b0;
			end else begin
				countReg <= countReg - 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// [dv/serial_flash_status_register_bench.sv]
// self-checking bench for the flash status register block
`timescale 1ns/10ps
`default_nettype none
`include "sfsr_defines.svh"
`define CHECK_EQ(got, want) begin samples_checked++; if ((got) !== (want)) begin errors++; \
	$display("unexpected at %0t: got %0h want %0h", $time, got, want); end end
module serial_flash_status_register_bench;
	logic        clk = 1'b0, rst_b = 1'b0, cmdValid = 1'b0, nvRestore = 1'b0;
	logic [7:0]  cmdCode = 8'h00, cmdData = 8'h00, readData;
	logic [23:0] cmdAddr = 24'h0, nvImage = 24'h0, arrayAddr;
	logic        busyFlag, writeLatch, arrayProgram, arrayErase, arrayChip, arrayDone;
	logic        suspendReq, resumeReq, abortReq, cmdRefused, lastRefused, lastStart;
	logic [2:0]  securityLocks, driveQuarters;
	logic [3:0]  dualDummy, quadDummy;
	int          errors = 0, samples_checked = 0, cycles = 0;
	always #12.5 clk = ~clk;
	serial_flash_status_register u_serial_flash_status_register (.clk(clk), .rst_b(rst_b),
		.cmdValid(cmdValid), .cmdCode(cmdCode), .cmdData(cmdData), .cmdAddr(cmdAddr),
		.arrayDone(arrayDone), .nvRestore(nvRestore), .nvImage(nvImage), .readData(readData),
		.busyFlag(busyFlag), .writeLatch(writeLatch), .arrayProgram(arrayProgram),
		.arrayErase(arrayErase), .arrayChip(arrayChip), .arrayAddr(arrayAddr),
		.suspendReq(suspendReq), .resumeReq(resumeReq), .abortReq(abortReq),
		.cmdRefused(cmdRefused), .securityLocks(securityLocks), .dualDummy(dualDummy),
		.quadDummy(quadDummy), .driveQuarters(driveQuarters));
	array_engine_model u_array_engine_model (.clk(clk), .rst_b(rst_b),
		.arrayProgram(arrayProgram), .arrayErase(arrayErase), .arrayChip(arrayChip),
		.suspendReq(suspendReq), .resumeReq(resumeReq), .abortReq(abortReq),
		.arrayDone(arrayDone));
	task automatic test_done();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// a hang in a wait loop is cut off here and reported as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			test_done();
		end
	end
	// pulses and registered answers are sampled just after the taking edge
	task automatic cmd(input logic [7:0] code, input logic [7:0] data = 8'h00,
			input logic [23:0] addr = 24'h0);
		@(posedge clk);
		cmdValid <= 1'b1;
		cmdCode <= code;
		cmdData <= data;
		cmdAddr <= addr;
		@(posedge clk);
		cmdValid <= 1'b0;
		#1;
		lastRefused = cmdRefused;
		lastStart = arrayProgram | arrayErase | arrayChip;
	endtask
	task automatic rd(input logic [7:0] code, input logic [7:0] want);
		cmd(code);
		`CHECK_EQ(readData, want)
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 300 && busyFlag !== 1'b0; i++) begin
			@(posedge clk);
			#1;
		end
		`CHECK_EQ(busyFlag, 1'b0)
	endtask
	task automatic wr(input logic [7:0] code, input logic [7:0] data, input logic [23:0] addr = 0);
		cmd(`CMD_WRITE_ENABLE);
		cmd(code, data, addr);
		if (lastRefused !== 1'b1) begin
			`CHECK_EQ(busyFlag, 1'b1)
			wait_idle();
			`CHECK_EQ(writeLatch, 1'b0)
		end
	endtask
	initial begin
		logic [7:0] b3;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		#1;
		`CHECK_EQ({dualDummy, quadDummy, driveQuarters}, {4'h4, 4'h6, 3'h3})
		rd(`CMD_READ_ONE, 8'h00);
		rd(`CMD_READ_TWO, 8'h02);
		rd(`CMD_READ_THREE, 8'h20);
		cmd(`CMD_STATUS_ONE, 8'h04);
		`CHECK_EQ(lastRefused, 1'b1)
		cmd(`CMD_WRITE_ENABLE);
		`CHECK_EQ(writeLatch, 1'b1)
		cmd(`CMD_WRITE_DISABLE);
		`CHECK_EQ(writeLatch, 1'b0)
		// drive code i with the dummy select following its low bit; reserved bits stay 0
		for (int i = 0; i < 4; i++) begin
			b3 = {1'b0, 2'(i), 4'h0, 1'(i)};
			wr(`CMD_STATUS_THREE, b3);
			`CHECK_EQ(driveQuarters, 3'(4 - i))
			`CHECK_EQ(dualDummy, (i % 2) ? 4'h8 : 4'h4)
			`CHECK_EQ(quadDummy, (i % 2) ? 4'hA : 4'h6)
			rd(`CMD_READ_THREE, b3);
		end
		wr(`CMD_STATUS_TWO, 8'h08);
		wr(`CMD_STATUS_TWO, 8'h00);
		`CHECK_EQ(securityLocks, 3'b001)
		rd(`CMD_READ_TWO, 8'h0A);
		wr(`CMD_STATUS_ONE, 8'h04);
		wr(`CMD_PAGE_WRITE, 8'h00, 24'h3F0000);
		`CHECK_EQ({lastRefused, lastStart}, 2'b10)
		wr(`CMD_CHIP_WIPE_A, 8'h00);
		`CHECK_EQ({lastRefused, lastStart}, 2'b10)
		wr(`CMD_PAGE_WRITE, 8'h00, 24'h000100);
		`CHECK_EQ({lastRefused, arrayAddr}, {1'b0, 24'h000100})
		cmd(`CMD_WRITE_ENABLE);
		cmd(`CMD_PAGE_WRITE, 8'h00, 24'h000200);
		cmd(`CMD_SUSPEND);
		`CHECK_EQ(busyFlag, 1'b0)
		rd(`CMD_READ_TWO, 8'h0E);
		cmd(`CMD_RESUME);
		`CHECK_EQ(busyFlag, 1'b1)
		rd(`CMD_READ_TWO, 8'h0A);
		wait_idle();
		cmd(`CMD_WRITE_ENABLE);
		cmd(`CMD_SECTOR_WIPE, 8'h00, 24'h001000);
		cmd(`CMD_SUSPEND);
		rd(`CMD_READ_TWO, 8'h8A);
		cmd(`CMD_RESET_ARM);
		cmd(`CMD_RESET_GO);
		`CHECK_EQ({busyFlag, writeLatch}, 2'b00)
		rd(`CMD_READ_TWO, 8'h0A);
		wr(`CMD_STATUS_ONE, 8'h00);
		wr(`CMD_CHIP_WIPE_B, 8'h00);
		`CHECK_EQ({lastRefused, lastStart}, 2'b01)
		// range bits 2..0 all set with invert set leaves nothing protected, so chip erase runs
		wr(`CMD_STATUS_TWO, 8'h48);
		wr(`CMD_STATUS_ONE, 8'h1C);
		wr(`CMD_CHIP_WIPE_B, 8'h00);
		`CHECK_EQ({lastRefused, lastStart}, 2'b01)
		rd(`CMD_READ_TWO, 8'h4A);
		wr(`CMD_STATUS_TWO, 8'h49);
		rd(`CMD_READ_TWO, 8'h4B);
		wr(`CMD_STATUS_TWO, 8'h41);
		wr(`CMD_STATUS_ONE, 8'h00);
		`CHECK_EQ(lastRefused, 1'b1)
		@(posedge clk);
		nvRestore <= 1'b1;
		nvImage <= 24'h200900;
		@(posedge clk);
		nvRestore <= 1'b0;
		#1;
		rd(`CMD_READ_TWO, 8'h0A);
		wr(`CMD_STATUS_ONE, 8'h00);
		`CHECK_EQ(lastRefused, 1'b0)
		test_done();
	end
endmodule
`default_nettype wire

// [verilog/serial_flash_status_register.sv]
// status and configuration register set of a serial nor flash
// Overview of operation
// - busy flag in bit 0 is 1 during program, erase or status write
// - write latch in bit 1; when 0 status writes, programs and erases are refused
// - five protect range bits in bits 6..2, changed by status write
// - program and erase targets inside the protected region are rejected
// - chip erase only with range 2..0 all 0 and invert 0, or all 1 and invert 1
// - two status guard bits, bit 7 low and bit 8 high, readable and writable
// - guard 00 writable with latch, 10 locked till power cycle, 11 locked forever
// - power cycle turns guard 10 back into 00
// - quad lines bit 9 always reads 1, writes ignored
// - three one-time lock bits 13..11, settable singly, never cleared
// - invert protect bit 14, default 0, combined with range bits
// - suspend sets bit 15 for erase, bit 10 for program
// - resume, software reset and power cycle clear both suspend flags
// - dummy select bit 16 gives 4 or 8 dual io dummy cycles
// - dummy select gives 6 or 10 quad io dummy cycles
// - strength field 22..21: 00 full, 01 three quarters, 10 half, 11 quarter
// - write enable command sets the write latch
// - latch cleared by reset, write disable, status write, program or erase end
`timescale 1ns/10ps
`default_nettype none
`include "sfsr_defines.svh"
module serial_flash_status_register (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        cmdValid,
	input  wire logic [7:0]  cmdCode,
	input  wire logic [7:0]  cmdData,
	input  wire logic [23:0] cmdAddr,
	input  wire logic        arrayDone,
	input  wire logic        nvRestore,
	input  wire logic [23:0] nvImage,
	output logic      [7:0]  readData,
	output logic             busyFlag,
	output logic             writeLatch,
	output logic             arrayProgram,
	output logic             arrayErase,
	output logic             arrayChip,
	output logic      [23:0] arrayAddr,
	output logic             suspendReq,
	output logic             resumeReq,
	output logic             abortReq,
	output logic             cmdRefused,
	output logic      [2:0]  securityLocks,
	output logic      [3:0]  dualDummy,
	output logic      [3:0]  quadDummy,
	output logic      [2:0]  driveQuarters
);
	sfsr_pkg::op_state_e stateReg;
	sfsr_pkg::op_state_e stateNext;
	logic [7:0] srCountReg;
	logic       latchReg;
	logic       armReg;
	logic [4:0] rangeReg;
	logic       guardLowReg;
	logic       guardHighReg;
	logic       invReg;
	logic [2:0] locksReg;
	logic       dummySelReg;
	logic [1:0] driveReg;

	wire isIdle   = stateReg == sfsr_pkg::OP_IDLE;
	wire isHeld   = (stateReg == sfsr_pkg::OP_PROG_HELD) || (stateReg == sfsr_pkg::OP_ERASE_HELD);
	wire isArray  = (stateReg == sfsr_pkg::OP_PROGRAM) || (stateReg == sfsr_pkg::OP_ERASE);
	wire wrOne    = cmdValid && (cmdCode == `CMD_STATUS_ONE);
	wire wrTwo    = cmdValid && (cmdCode == `CMD_STATUS_TWO);
	wire wrThree  = cmdValid && (cmdCode == `CMD_STATUS_THREE);
	wire srWrite  = wrOne || wrTwo || wrThree;
	wire progCmd  = cmdValid && ((cmdCode == `CMD_PAGE_WRITE) || (cmdCode == `CMD_QUAD_WRITE));
	wire eraseCmd = cmdValid && ((cmdCode == `CMD_SECTOR_WIPE) ||
		(cmdCode == `CMD_BLOCK32_WIPE) || (cmdCode == `CMD_BLOCK64_WIPE));
	wire chipCmd  = cmdValid && ((cmdCode == `CMD_CHIP_WIPE_A) || (cmdCode == `CMD_CHIP_WIPE_B));
	wire readCmd  = cmdValid && ((cmdCode == `CMD_READ_ONE) ||
		(cmdCode == `CMD_READ_TWO) || (cmdCode == `CMD_READ_THREE));
	wire enCmd    = cmdValid && (cmdCode == `CMD_WRITE_ENABLE);
	wire disCmd   = cmdValid && (cmdCode == `CMD_WRITE_DISABLE);
	wire armCmd   = cmdValid && (cmdCode == `CMD_RESET_ARM);
	wire swReset  = cmdValid && (cmdCode == `CMD_RESET_GO) && armReg;

	// guard 01 has no hardware-pin lock here, so it behaves like 00
	wire guardOpen = !guardHighReg;
	wire srGo      = srWrite && latchReg && isIdle && guardOpen;

	// protected region: mask off the address bits below the region size
	wire [2:0] rangeLow   = rangeReg[2:0];
	wire [2:0] smallStep  = (rangeLow > `SMALL_MAX_STEP) ? `SMALL_MAX_STEP : rangeLow;
	wire [4:0] keepBits   = rangeReg[4] ? (`SMALL_BASE_SHIFT + {2'h0, smallStep}) :
		(`BIG_BASE_SHIFT + {2'h0, rangeLow});
	wire [`ARRAY_ADDR_W-1:0] lowOnes    = (`ARRAY_ADDR_W'(1) << keepBits) - `ARRAY_ADDR_W'(1);
	wire [`ARRAY_ADDR_W-1:0] regionMask = ~lowOnes;
	wire [`ARRAY_ADDR_W-1:0] maskedAddr = cmdAddr[`ARRAY_ADDR_W-1:0] & regionMask;
	wire atTop     = maskedAddr == regionMask;
	wire atBottom  = maskedAddr == '0;
	wire inRange   = (rangeLow == 3'h0) ? 1'b0 :
		(rangeLow == `RANGE_ALL) ? 1'b1 : (rangeReg[3] ? atBottom : atTop);
	wire addrProt  = invReg ^ inRange;
	wire chipOk    = ((rangeLow == 3'h0) && !invReg) ||
		((rangeLow == `RANGE_ALL) && invReg);

	wire progGo  = progCmd && latchReg && isIdle && !addrProt;
	wire eraseGo = eraseCmd && latchReg && isIdle && !addrProt;
	wire chipGo  = chipCmd && latchReg && isIdle && chipOk;
	wire arrayGo = progGo || eraseGo || chipGo;
	wire suspendCmd = cmdValid && (cmdCode == `CMD_SUSPEND) && isArray;
	wire resumeCmd  = cmdValid && (cmdCode == `CMD_RESUME) && isHeld;
	wire srDone     = (stateReg == sfsr_pkg::OP_STATUS) && (srCountReg == 8'h00);
	wire arrayFin   = arrayDone && isArray;
	wire refused    = (srWrite && !srGo) || (progCmd && !progGo) ||
		(eraseCmd && !eraseGo) || (chipCmd && !chipGo);

	wire [7:0] byteOne   = {guardLowReg, rangeReg, latchReg, busyFlag};
	wire [7:0] byteTwo   = {stateReg == sfsr_pkg::OP_ERASE_HELD, invReg, locksReg,
		stateReg == sfsr_pkg::OP_PROG_HELD, 1'b1, guardHighReg};
	wire [7:0] byteThree = {1'b0, driveReg, 4'h0, dummySelReg};
	wire [7:0] readSel   = (cmdCode == `CMD_READ_ONE) ? byteOne :
		(cmdCode == `CMD_READ_TWO) ? byteTwo : byteThree;

	// busy covers status timer and running array work, not a held suspend
	assign busyFlag = (stateReg == sfsr_pkg::OP_STATUS) || isArray;
	assign writeLatch = latchReg;

	always_comb begin
		stateNext = stateReg;
		case (stateReg)
			sfsr_pkg::OP_IDLE: begin
				if (srGo)
					stateNext = sfsr_pkg::OP_STATUS;
				else if (progGo)
					stateNext = sfsr_pkg::OP_PROGRAM;
				else if (eraseGo || chipGo)
					stateNext = sfsr_pkg::OP_ERASE;
			end
			sfsr_pkg::OP_STATUS: begin
				if (srDone)
					stateNext = sfsr_pkg::OP_IDLE;
			end
			sfsr_pkg::OP_PROGRAM: begin
				if (suspendCmd)
					stateNext = sfsr_pkg::OP_PROG_HELD;
				else if (arrayDone)
					stateNext = sfsr_pkg::OP_IDLE;
			end
			sfsr_pkg::OP_ERASE: begin
				if (suspendCmd)
					stateNext = sfsr_pkg::OP_ERASE_HELD;
				else if (arrayDone)
					stateNext = sfsr_pkg::OP_IDLE;
			end
			sfsr_pkg::OP_PROG_HELD: begin
				if (resumeCmd)
					stateNext = sfsr_pkg::OP_PROGRAM;
			end
			sfsr_pkg::OP_ERASE_HELD: begin
				if (resumeCmd)
					stateNext = sfsr_pkg::OP_ERASE;
			end
			default: stateNext = sfsr_pkg::OP_IDLE;
		endcase
		// software reset abandons any held or running work
		if (swReset)
			stateNext = sfsr_pkg::OP_IDLE;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			stateReg <= sfsr_pkg::OP_IDLE;
		else
			stateReg <= stateNext;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			srCountReg <= 8'h00;
		else if (srGo)
			srCountReg <= `SR_WRITE_CYCLES;
		else if (srCountReg != 8'h00)
			srCountReg <= srCountReg - 8'h01;
	end

	// clears take priority; enable is only taken when nothing runs
	always_ff @(posedge clk) begin
		if (!rst_b)
			latchReg <= 1'b0;
		else if (disCmd || swReset || srDone || arrayFin)
			latchReg <= 1'b0;
		else if (enCmd && !busyFlag)
			latchReg <= 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			armReg <= 1'b0;
		else if (cmdValid)
			armReg <= armCmd;
	end

	// reset stands for a power cycle; nvRestore reloads the stored image
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			rangeReg    <= `RANGE_RESET;
			guardLowReg <= 1'b0;
		end else if (nvRestore) begin
			rangeReg    <= nvImage[`B1_RANGE_HI:`B1_RANGE_LO];
			guardLowReg <= nvImage[`B1_GUARD_LOW];
		end else if (srGo && wrOne) begin
			rangeReg    <= cmdData[`B1_RANGE_HI:`B1_RANGE_LO];
			guardLowReg <= cmdData[`B1_GUARD_LOW];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			guardHighReg <= 1'b0;
			invReg       <= 1'b0;
			locksReg     <= 3'h0;
		end else if (nvRestore) begin
			// power-supply lock does not survive the cycle
			guardHighReg <= nvImage[`IMG_B2 + `B2_GUARD_HIGH] &
				nvImage[`B1_GUARD_LOW];
			invReg       <= nvImage[`IMG_B2 + `B2_INVERT];
			locksReg     <= nvImage[`IMG_B2 + `B2_LOCK_HI:`IMG_B2 + `B2_LOCK_LO];
		end else if (srGo && wrTwo) begin
			guardHighReg <= cmdData[`B2_GUARD_HIGH];
			invReg       <= cmdData[`B2_INVERT];
			locksReg     <= locksReg | cmdData[`B2_LOCK_HI:`B2_LOCK_LO];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dummySelReg <= 1'b0;
			driveReg    <= `DRIVE_RESET;
		end else if (nvRestore) begin
			dummySelReg <= nvImage[`IMG_B3 + `B3_DUMMY];
			driveReg    <= nvImage[`IMG_B3 + `B3_DRIVE_HI:`IMG_B3 + `B3_DRIVE_LO];
		end else if (srGo && wrThree) begin
			dummySelReg <= cmdData[`B3_DUMMY];
			driveReg    <= cmdData[`B3_DRIVE_HI:`B3_DRIVE_LO];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			readData <= 8'h00;
		else if (readCmd)
			readData <= readSel;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			arrayProgram <= 1'b0;
			arrayErase   <= 1'b0;
			arrayChip    <= 1'b0;
			suspendReq   <= 1'b0;
			resumeReq    <= 1'b0;
			abortReq     <= 1'b0;
			cmdRefused   <= 1'b0;
		end else begin
			arrayProgram <= progGo;
			arrayErase   <= eraseGo;
			arrayChip    <= chipGo;
			suspendReq   <= suspendCmd;
			resumeReq    <= resumeCmd;
			abortReq     <= swReset && !isIdle;
			cmdRefused   <= refused;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b)
			arrayAddr <= 24'h000000;
		else if (arrayGo)
			arrayAddr <= cmdAddr;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dualDummy     <= `DUAL_SHORT;
			quadDummy     <= `QUAD_SHORT;
			driveQuarters <= `FULL_QUARTERS - 3'h1;
			securityLocks <= 3'h0;
		end else begin
			dualDummy     <= dummySelReg ? `DUAL_LONG : `DUAL_SHORT;
			quadDummy     <= dummySelReg ? `QUAD_LONG : `QUAD_SHORT;
			driveQuarters <= `FULL_QUARTERS - {1'b0, driveReg};
			securityLocks <= locksReg;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	status_busy_a: assert property (srGo |=> busyFlag [*8])
		else $error("busy dropped during status write");
	latch_gate_a: assert property (wrOne && !latchReg && !nvRestore |=> $stable(rangeReg))
		else $error("status write taken without latch");
	range_write_a: assert property (srGo && wrOne && !nvRestore
		|=> rangeReg == $past(cmdData[6:2]))
		else $error("protect range not written");
	prot_reject_a: assert property (progCmd && addrProt |=> !arrayProgram)
		else $error("program into protected region started");
	chip_guard_a: assert property (chipCmd && !chipOk |=> !arrayChip && cmdRefused)
		else $error("chip erase started while protected");
	guard_lock_a: assert property (wrTwo && guardHighReg && !nvRestore
		|=> $stable(invReg) && $stable(guardHighReg))
		else $error("locked status register changed");
	guard_restore_a: assert property (nvRestore && nvImage[8] && !nvImage[7]
		|=> !guardHighReg && !guardLowReg)
		else $error("power lock survived restore");
	quad_fixed_a: assert property (readCmd && cmdCode == `CMD_READ_TWO |=> readData[1])
		else $error("quad bit read as zero");
	lock_sticky_a: assert property (!nvRestore |=> ($past(locksReg) & ~locksReg) == 3'h0)
		else $error("security lock cleared");
	suspend_set_a: assert property (suspendCmd && stateReg == sfsr_pkg::OP_ERASE && !swReset
		|=> stateReg == sfsr_pkg::OP_ERASE_HELD ##1 !busyFlag || resumeReq)
		else $error("erase suspend not flagged");
	resume_clear_a: assert property (resumeCmd || swReset |=> !isHeld)
		else $error("suspend flag survived resume");
	dummy_sel_a: assert property (dummySelReg |=> dualDummy == 4'h8 && quadDummy == 4'hA)
		else $error("dummy count wrong");
	latch_clear_a: assert property (srDone || arrayFin |=> !latchReg)
		else $error("latch kept after completion");
	latch_set_a: assert property (enCmd && !busyFlag && !disCmd |=> latchReg)
		else $error("write enable ignored");
endmodule
`default_nettype wire

// [verilog/sfsr_defines.svh]
// named constants for the flash status register block
`ifndef SFSR_DEFINES_SVH
`define SFSR_DEFINES_SVH
`define CMD_WRITE_ENABLE   8'h06
`define CMD_WRITE_DISABLE  8'h04
`define CMD_READ_ONE       8'h05
`define CMD_READ_TWO       8'h35
`define CMD_READ_THREE     8'h15
`define CMD_STATUS_ONE     8'h01
`define CMD_STATUS_TWO     8'h31
`define CMD_STATUS_THREE   8'h11
`define CMD_PAGE_WRITE     8'h02
`define CMD_QUAD_WRITE     8'h32
`define CMD_SECTOR_WIPE    8'h20
`define CMD_BLOCK32_WIPE   8'h52
`define CMD_BLOCK64_WIPE   8'hD8
`define CMD_CHIP_WIPE_A    8'h60
`define CMD_CHIP_WIPE_B    8'hC7
`define CMD_SUSPEND        8'h75
`define CMD_RESUME         8'h7A
`define CMD_RESET_ARM      8'h66
`define CMD_RESET_GO       8'h99
`define B1_GUARD_LOW       7
`define B1_RANGE_HI        6
`define B1_RANGE_LO        2
`define B2_GUARD_HIGH      0
`define B2_LOCK_HI         5
`define B2_LOCK_LO         3
`define B2_INVERT          6
`define B3_DUMMY           0
`define B3_DRIVE_HI        6
`define B3_DRIVE_LO        5
`define IMG_B2             8
`define IMG_B3             16
`define RANGE_RESET        5'h00
`define DRIVE_RESET        2'h1
`define SR_WRITE_CYCLES    8'h10
`define DUAL_SHORT         4'h4
`define DUAL_LONG          4'h8
`define QUAD_SHORT         4'h6
`define QUAD_LONG          4'hA
`define FULL_QUARTERS      3'h4
`define SMALL_BASE_SHIFT   5'h0B
`define BIG_BASE_SHIFT     5'h0F
`define SMALL_MAX_STEP     3'h4
`define RANGE_ALL          3'h7
`define ARRAY_ADDR_W       22
`endif

// [verilog/sfsr_pkg.sv]
// types for the flash status register block
package sfsr_pkg;
	typedef enum logic [2:0] {
		OP_IDLE,
		OP_STATUS,
		OP_PROGRAM,
		OP_ERASE,
		OP_PROG_HELD,
		OP_ERASE_HELD
	} op_state_e;
endpackage
